/* design/see_consts.svh */
/*
 * constants of the serial memory pin-control block: instruction codes,
 * status bit positions, reset values and the internal write time.
 * assumes it is included by bare name from the modules.
 */
`ifndef SEE_CONSTS_SVH
`define SEE_CONSTS_SVH

// ************************************************************
// instruction codes
// ************************************************************
`define SEE_OP_WRITE_ENABLE   8'h06
`define SEE_OP_WRITE_DISABLE  8'h04
`define SEE_OP_READ_STATUS    8'h05
`define SEE_OP_WRITE_STATUS   8'h01

// ************************************************************
// status register layout
// ************************************************************
`define SEE_SR_PROT_EN_BIT    7
`define SEE_SR_WR_LATCH_BIT   1
`define SEE_SR_WIP_BIT        0
`define SEE_SR_NV_MASK        8'h8c
`define SEE_SR_RESET          8'h00

// ************************************************************
// frame bit counts
// ************************************************************
`define SEE_OP_BITS           5'h08
`define SEE_OP_DATA_BITS      5'h10
`define SEE_BITS_SATURATE     5'h1f

// ************************************************************
// timing
// ************************************************************
`define SEE_CLK_PERIOD_NS     10
`define SEE_WRITE_TIME_NS     5000000
`define SEE_WRITE_CYCLES      (`SEE_WRITE_TIME_NS / `SEE_CLK_PERIOD_NS)

`endif

/* design/see_pkg.sv */
/*
 * types shared by the pin-control block and its write timer.
 * assumes see_consts.svh is on the include path.
 */
package see_pkg;

   // ************************************************************
   // frame result handed from the serial clock domain
   // ************************************************************
   typedef enum logic [1:0] {
      SEE_LEN_NONE,
      SEE_LEN_OP,
      SEE_LEN_OP_DATA,
      SEE_LEN_OTHER
   } see_len_t;

   typedef struct packed {
      logic [7:0] op;
      logic [7:0] data;
      see_len_t   len;
   } see_frame_t;

   typedef enum logic {
      SEE_TMR_IDLE,
      SEE_TMR_RUN
   } see_tmr_state_t;

endpackage : see_pkg

/* design/see_write_timer.sv */
/*
 * self-timed internal write cycle: a start pulse runs a fixed count,
 * busy stays high meanwhile, done pulses once at the end.
 * assumes start comes from logic on clk and is a one-cycle pulse.
 */
`timescale 1ns/1ns
`include "see_consts.svh"

module see_write_timer #(
   parameter int unsigned CYCLES = `SEE_WRITE_CYCLES
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   input  wire logic start,
   output logic      busy,
   output logic      done
);

   localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;

   see_pkg::see_tmr_state_t state;
   logic [CW-1:0]           count;

   // ************************************************************
   // cycle counter
   // ************************************************************
   // once started nothing but reset stops it
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state <= see_pkg::SEE_TMR_IDLE;
         count <= '0;
         done  <= 1'b0;
      end
      else if (ce)
      begin
         done <= 1'b0;
         unique case (state)
            see_pkg::SEE_TMR_IDLE:
            begin
               if (start)
               begin
                  state <= see_pkg::SEE_TMR_RUN;
                  count <= CW'(CYCLES - 1);
               end
            end
            see_pkg::SEE_TMR_RUN:
            begin
               if (count == '0)
               begin
                  state <= see_pkg::SEE_TMR_IDLE;
                  done  <= 1'b1;
               end
               else
               begin
                  count <= count - 1'b1;
               end
            end
         endcase
      end
   end

   assign busy = (state == see_pkg::SEE_TMR_RUN);

endmodule : see_write_timer

/* design/see_pin_ctrl.sv */
/*
 * slave-side pin control of a serial memory: selection, output
 * tri-state, bit capture and shift-out on the serial clock, hold
 * pause, write protect pin, and the launch of the internal write.
 * assumes the serial clock only runs while chip select is low and
 * that the master keeps hold high unless it pauses a transfer.
 */
// How it works
// - chip select low selects the device; high deselects into standby
// - a started write runs to its end; standby follows once it finishes
// - serial output floats whenever the device is deselected
// - chip select rising after a complete valid write launches the write
// - frames count from the first clock after reset, as the chip select synchroniser resets high
// - read bits go onto serial output after each serial clock falling edge
// - protect pin low with enable bit high refuses status writes only
// - protect pin high lets every function, status writes too, proceed
// - protect pin low during a status write frame aborts it; later falls do not
// - protect enable bit low makes the protect pin ignored
// - serial input bits are captured on each serial clock rising edge
// - hold low mid-frame pauses and keeps the place in the frame
// - hold lowered pauses at once, whatever the clock level
// - while paused, input, clock and output pins are ignored and float
// - pause ends as soon as hold rises, whatever the clock level
// - hold low always floats serial output
// - reset clears the write enable latch
// - protect enable sits in status bit 7, write enable latch in bit 1
`timescale 1ns/1ns
`include "see_consts.svh"

module see_pin_ctrl #(
   parameter int unsigned WRITE_CYCLES = `SEE_WRITE_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic       sck,
   input  wire logic       cs_n,
   input  wire logic       si,
   input  wire logic       wp_n,
   input  wire logic       hold_n,
   output logic            so,
   output logic            so_oe,
   output logic            standby,
   output logic            write_busy,
   output logic [7:0]      status
);

   // ************************************************************
   // decoding used by the commit logic only
   // ************************************************************
   function automatic logic is_cmd(input see_pkg::see_frame_t f,
                                   input logic [7:0]          code,
                                   input see_pkg::see_len_t   len);
      is_cmd = (f.op == code) && (f.len == len);
   endfunction : is_cmd

   // ************************************************************
   // serial clock domain: capture, pause, shift-out
   // ************************************************************
   logic                link_clr;
   logic [4:0]          bit_cnt;
   logic [7:0]          rx;
   see_pkg::see_frame_t frame;
   logic                paused;
   logic [2:0]          out_idx;
   logic [7:0]          status_meta;
   logic [7:0]          status_link;

   assign link_clr = rst | cs_n;

   // hold low at a rising edge means paused; raising it resumes
   // lowered with the clock high, the fall in between already froze the output
   assign paused = ~hold_n;

   // status word is stable for many edges before a read reaches it
   always_ff @(posedge sck or posedge rst)
   begin
      if (rst)
      begin
         status_meta <= `SEE_SR_RESET;
         status_link <= `SEE_SR_RESET;
      end
      else
      begin
         status_meta <= status;
         status_link <= status_meta;
      end
   end

   always_ff @(posedge sck or posedge link_clr)
   begin
      if (link_clr)
      begin
         bit_cnt <= 5'h00;
         rx      <= 8'h00;
      end
      else if (!paused)
      begin
         rx <= {rx[6:0], si};
         if (bit_cnt != `SEE_BITS_SATURATE)
            bit_cnt <= bit_cnt + 5'h01;
      end
   end

   // frame result survives deselect so the commit side can read it
   always_ff @(posedge sck or posedge rst)
   begin
      if (rst)
      begin
         frame <= '{op: 8'h00, data: 8'h00, len: see_pkg::SEE_LEN_NONE};
      end
      else if (!cs_n && !paused)
      begin
         if (bit_cnt == 5'h00)
            frame.len <= see_pkg::SEE_LEN_NONE;
         else if (bit_cnt == `SEE_OP_BITS - 5'h01)
         begin
            frame.op  <= {rx[6:0], si};
            frame.len <= see_pkg::SEE_LEN_OP;
         end
         else if (bit_cnt == `SEE_OP_DATA_BITS - 5'h01)
         begin
            frame.data <= {rx[6:0], si};
            frame.len  <= see_pkg::SEE_LEN_OP_DATA;
         end
         else if (bit_cnt >= `SEE_OP_BITS)
            frame.len <= see_pkg::SEE_LEN_OTHER;
      end
   end

   always_ff @(negedge sck or posedge link_clr)
   begin
      if (link_clr)
      begin
         so      <= 1'b0;
         out_idx <= 3'h7;
      end
      // a fall with hold low starts the pause, no shift
      else if (!paused && bit_cnt >= `SEE_OP_BITS
               && frame.op == `SEE_OP_READ_STATUS)
      begin
         so      <= status_link[out_idx];
         out_idx <= out_idx - 3'h1;
      end
   end

   assign so_oe = ~cs_n & hold_n & (bit_cnt >= `SEE_OP_BITS)
                  & (frame.op == `SEE_OP_READ_STATUS);

   // ************************************************************
   // system clock domain: pin synchronisers
   // ************************************************************
   logic cs_meta;
   logic cs_sync;
   logic cs_prev;
   logic wp_meta;
   logic wp_sync;
   logic cs_rise;
   logic cs_fall;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cs_meta <= 1'b1;
         cs_sync <= 1'b1;
         cs_prev <= 1'b1;
         wp_meta <= 1'b1;
         wp_sync <= 1'b1;
      end
      else if (ce)
      begin
         cs_meta <= cs_n;
         cs_sync <= cs_meta;
         cs_prev <= cs_sync;
         wp_meta <= wp_n;
         wp_sync <= wp_meta;
      end
   end

   assign cs_rise = cs_sync & ~cs_prev;
   assign cs_fall = ~cs_sync & cs_prev;

   // ************************************************************
   // arming and protect-pin watch
   // ************************************************************
   logic armed;
   logic frame_armed;
   logic wp_low_seen;

   // a frame counts if its fall is seen after reset; cs_sync resets high, so armed sets at once
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         armed       <= 1'b0;
         frame_armed <= 1'b0;
      end
      else if (ce)
      begin
         if (cs_sync)
            armed <= 1'b1;
         if (cs_fall)
            frame_armed <= armed;
      end
   end

   // protect pin low anywhere in the frame
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         wp_low_seen <= 1'b0;
      else if (ce)
      begin
         if (cs_fall)
            wp_low_seen <= ~wp_sync;
         else if (!cs_sync && !wp_sync)
            wp_low_seen <= 1'b1;
      end
   end

   // ************************************************************
   // commit at deselect and internal write
   // ************************************************************
   logic       write_protect_enable_bit;
   logic       write_enable_latch;
   logic [7:0] nv_bits;
   logic [7:0] nv_pending;
   logic       tmr_start;
   logic       tmr_busy;
   logic       tmr_done;
   logic       commit;
   logic       status_ok;

   assign commit = cs_rise & frame_armed & ~tmr_busy;

   // refuse while pin low and enable set
   assign status_ok = ~write_protect_enable_bit | (wp_sync & ~wp_low_seen);

   assign tmr_start = commit & write_enable_latch & status_ok
                      & is_cmd(frame, `SEE_OP_WRITE_STATUS, see_pkg::SEE_LEN_OP_DATA);

   see_write_timer #(
      .CYCLES (WRITE_CYCLES)
   ) u_timer (
      .clk   (clk),
      .rst   (rst),
      .ce    (ce),
      .start (tmr_start),
      .busy  (tmr_busy),
      .done  (tmr_done)
   );

   // latch cleared by reset
   // a write enable landing with the end of a write wins over its clear
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         write_enable_latch <= 1'b0;
      else if (ce)
      begin
         if (commit
             && is_cmd(frame, `SEE_OP_WRITE_ENABLE, see_pkg::SEE_LEN_OP))
            write_enable_latch <= 1'b1;
         else if (tmr_done)
            write_enable_latch <= 1'b0;
         else if (commit
                  && is_cmd(frame, `SEE_OP_WRITE_DISABLE, see_pkg::SEE_LEN_OP))
            write_enable_latch <= 1'b0;
      end
   end

   // write completes whatever chip select does
   // pin fall after launch has no effect
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         nv_bits    <= `SEE_SR_RESET & `SEE_SR_NV_MASK;
         nv_pending <= `SEE_SR_RESET & `SEE_SR_NV_MASK;
      end
      else if (ce)
      begin
         if (tmr_start)
            nv_pending <= frame.data & `SEE_SR_NV_MASK;
         if (tmr_done)
            nv_bits <= nv_pending;
      end
   end

   assign write_protect_enable_bit = nv_bits[`SEE_SR_PROT_EN_BIT];

   // ************************************************************
   // outputs
   // ************************************************************
   // latch and busy positions
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         status     <= `SEE_SR_RESET;
         standby    <= 1'b1;
         write_busy <= 1'b0;
      end
      else if (ce)
      begin
         status                   <= nv_bits;
         status[`SEE_SR_WR_LATCH_BIT] <= write_enable_latch;
         status[`SEE_SR_WIP_BIT]  <= tmr_busy;
         standby                  <= cs_sync & ~tmr_busy;
         write_busy               <= tmr_busy;
      end
   end

endmodule : see_pin_ctrl

/* tb/see_pin_ctrl_properties.sv */
/* port checker of the pin-control block.
   assumes a bind onto see_pin_ctrl with ce held high. */
`timescale 1ns/1ns

module see_pin_ctrl_chk #(
   parameter int unsigned WRITE_CYCLES = 20
) (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       cs_n,
   input wire logic       hold_n,
   input wire logic       so_oe,
   input wire logic       standby,
   input wire logic       write_busy,
   input wire logic [7:0] status
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   // ********
   // write length
   // ********
   int unsigned cnt;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         cnt <= 0;
      else if (write_busy)
         cnt <= cnt + 1;
      else
         cnt <= 0;
   end
   // ********
   // properties
   // ********
   // deselected floats
   property p_desel; cs_n |-> !so_oe; endproperty
   a_desel: assert property (p_desel) else $error("so driven deselected");
   property p_hold; !hold_n |-> !so_oe; endproperty
   a_hold: assert property (p_hold) else $error("so driven in hold");
   property p_rst; $fell(rst) |-> status == 8'h00 && standby; endproperty
   a_rst: assert property (p_rst) else $error("bad reset state");
   property p_busy; write_busy |-> !standby; endproperty
   a_busy: assert property (p_busy) else $error("standby during write");
   property p_sel; !cs_n [*5] |-> !standby; endproperty
   a_sel: assert property (p_sel) else $error("standby while selected");
   property p_launch; $rose(write_busy) |-> cs_n; endproperty
   a_launch: assert property (p_launch) else $error("write while selected");
   property p_wip; $rose(write_busy) |-> ##[0:1] status[0]; endproperty
   a_wip: assert property (p_wip) else $error("busy bit missing");
   property p_wel; $rose(status[1]) |-> cs_n; endproperty
   a_wel: assert property (p_wel) else $error("latch set mid frame");
   property p_len;
      $fell(write_busy) |-> cnt >= WRITE_CYCLES - 1 && cnt <= WRITE_CYCLES + 1;
   endproperty
   a_len: assert property (p_len) else $error("write length wrong");
   // nonvolatile bits only at write end
   property p_nv;
      $changed({status[7], status[3:2]}) |-> $past(write_busy) || $past(write_busy, 2);
   endproperty
   a_nv: assert property (p_nv) else $error("status bits changed early");
   c_write: cover property ($rose(write_busy));
   c_pause: cover property (!cs_n && $fell(hold_n));
   c_wel: cover property ($rose(status[1]));
endmodule : see_pin_ctrl_chk

bind see_pin_ctrl see_pin_ctrl_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_see_pin_ctrl_chk (
   .clk(clk), .rst(rst), .cs_n(cs_n), .hold_n(hold_n), .so_oe(so_oe),
   .standby(standby), .write_busy(write_busy), .status(status)
);

/* tb/see_spi_master.sv */
/* link master model: one frame per xfer call, optional pause.
   assumes the bench calls xfer from one process only. */
`timescale 1ns/1ns
`include "see_consts.svh"

module see_spi_master (
   output logic      sck,
   output logic      cs_n,
   output logic      si,
   output logic      hold_n,
   input  wire logic so,
   input  wire logic so_oe
);
   localparam int HALF = 24;
   logic [7:0] rx;
   event       got;
   initial
   begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
      hold_n = 1'b1;
   end
   task automatic xfer(input int n, input logic [15:0] tx, input int hold_at);
      logic [15:0] sh;
      sh = '0;
      #3 cs_n = 1'b0;
      #HALF;
      for (int i = n - 1; i >= 0; i--)
      begin
         si = tx[i];
         if (i == hold_at)
         begin
            // pause and resume with clock low, junk clocked meanwhile
            #(HALF / 2) hold_n = 1'b0;
            si = ~tx[i];
            #(HALF / 2) sck = 1'b1;
            #HALF sck = 1'b0;
            #(HALF / 2) hold_n = 1'b1;
            si = tx[i];
            #(HALF / 2);
         end
         // sample just ahead of the rise, before the device reacts to it
         #HALF sh = {sh[14:0], so_oe ? so : 1'bx};
         sck = 1'b1;
         #HALF sck = 1'b0;
      end
      // select rise commits; released data line flips
      #HALF cs_n = 1'b1;
      si = ~si;
      if (n == 16 && tx[15:8] == `SEE_OP_READ_STATUS)
      begin
         rx = sh[7:0];
         -> got;
      end
      #(5 * HALF);
   endtask : xfer
endmodule : see_spi_master

/* tb/spi_eeprom_pin_control_tb_top.sv */
/* self-checking bench: reset state, status reads, status writes
   with and without protection, a paused read.
   assumes the link master model and the bound checker. */
`timescale 1ns/1ns
`include "see_consts.svh"

`define CHK(g, e) \
   begin \
      num_checks++; \
      if ((g) !== (e)) \
      begin \
         bad_count++; \
         $display("CHECK FAILED at %0t: got %h want %h", $time, g, e); \
      end \
   end

module spi_eeprom_pin_control_tb_top;
   logic        clk;
   logic        rst;
   logic        ce;
   logic        wp_n;
   logic        sck;
   logic        cs_n;
   logic        si;
   logic        hold_n;
   logic        so;
   logic        so_oe;
   logic        standby;
   logic        write_busy;
   logic [7:0]  status;
   logic [7:0]  exp_q[$];
   logic [7:0]  exp;
   logic [31:0] seed;
   int          bad_count;
   int          num_checks;

   see_pin_ctrl #(.WRITE_CYCLES(20)) u_see_pin_ctrl (
      .clk(clk), .rst(rst), .ce(ce), .sck(sck), .cs_n(cs_n), .si(si),
      .wp_n(wp_n), .hold_n(hold_n), .so(so), .so_oe(so_oe),
      .standby(standby), .write_busy(write_busy), .status(status)
   );
   see_spi_master u_see_spi_master (
      .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so), .so_oe(so_oe)
   );

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs

   task automatic complete_run;
      if (bad_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc

   task automatic pin(input logic v);
      @(posedge clk);
      wp_n <= v;
      cyc(4);
   endtask : pin

   task automatic frm(input int n, input logic [15:0] tx);
      u_see_spi_master.xfer(n, tx, -1);
      cyc(1);
   endtask : frm

   task automatic rd(input logic [7:0] e, input int hold_at);
      exp_q.push_back(e);
      u_see_spi_master.xfer(16, {`SEE_OP_READ_STATUS, 8'h00}, hold_at);
   endtask : rd

   task automatic idle;
      int k;
      k = 0;
      while (write_busy !== 1'b0 && k < 100)
      begin
         cyc(1);
         k++;
      end
      `CHK(write_busy, 1'b0)
   endtask : idle

   task automatic wrsr(input logic [7:0] d, input logic go);
      frm(8, {8'h00, `SEE_OP_WRITE_ENABLE});
      frm(16, {`SEE_OP_WRITE_STATUS, d});
      `CHK(write_busy, go)
      if (go)
      begin
         `CHK(standby, 1'b0)
         idle();
         `CHK(standby, 1'b1)
      end
      else
         frm(8, {8'h00, `SEE_OP_WRITE_DISABLE});
   endtask : wrsr

   initial
   forever
   begin
      @(u_see_spi_master.got);
      exp = exp_q.pop_front();
      `CHK(u_see_spi_master.rx, exp)
   end

   initial
   begin
      #200000;
      bad_count++;
      complete_run();
   end

   initial
   begin
      rst = 1'b1;
      ce = 1'b1;
      wp_n = 1'b1;
      seed = 32'h1e632505;
      bad_count = 0;
      num_checks = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      cyc(4);
      `CHK(status, 8'h00)
      `CHK(standby, 1'b1)
      `CHK(so_oe, 1'b0)
      frm(16, {`SEE_OP_WRITE_STATUS, 8'h8c});
      `CHK(write_busy, 1'b0)
      rd(8'h00, -1);
      frm(8, {8'h00, `SEE_OP_WRITE_ENABLE});
      rd(8'h02, -1);
      frm(8, {8'h00, `SEE_OP_WRITE_DISABLE});
      wrsr(8'h8c, 1'b1);
      rd(8'h8c, 3);
      pin(1'b0);
      wrsr(8'h00, 1'b0);
      rd(8'h8c, -1);
      // pin falls only after the write has launched
      pin(1'b1);
      frm(8, {8'h00, `SEE_OP_WRITE_ENABLE});
      frm(16, {`SEE_OP_WRITE_STATUS, 8'h84});
      @(posedge clk);
      wp_n <= 1'b0;
      idle();
      rd(8'h84, -1);
      pin(1'b1);
      wrsr(8'h00, 1'b1);
      pin(1'b0);
      seed = xs(seed);
      wrsr(seed[7:0], 1'b1);
      rd(seed[7:0] & 8'h8c, -1);
      cyc(5);
      complete_run();
   end
endmodule : spi_eeprom_pin_control_tb_top
